// ---- clk_gen_pkg.sv ----
// Package for the clock generator status and loop control block.
// Assumes an Avalon-MM slave with 32-bit data, one register per aligned word.
package clk_gen_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFF_PLL_CONTROL = 4'h4;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'hC;
  localparam int ADDR_W = 4;

  // Status/control fields
  localparam int BIT_LOCK_LOSS = 7;
  localparam int BIT_OSC_READY = 1;
  localparam int BIT_FINE_TRIM = 0;

  // Loop control fields
  localparam int BIT_LOCK_LOSS_IE = 7;
  localparam int BIT_LOOP_SELECT = 6;
  localparam int BIT_CLK_MON_EN = 5;
  localparam int VCO_MULTIPLIER_FIELD_MSB = 3;

  // Interrupt status bits (also the enable register layout at the enable offset)
  localparam int IRQ_LOCK_LOSS = 0;
  localparam int IRQ_OSC_READY = 1;
  localparam int IRQ_CLK_LOSS = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [7:0] RST_PLL_CONTROL = 8'h01;
  localparam logic [7:0] RST_FINE_TRIM = 8'h00;

  // Multiplier table
  localparam logic [3:0] VCO_MULTIPLIER_FIELD_RESERVED = 4'h0;
  localparam logic [3:0] VCO_MULTIPLIER_FIELD_LAST = 4'hA;
  localparam logic [5:0] MULT_STEP = 6'h04;
  localparam logic [5:0] MULT_MAX = 6'h28;

  // Oscillator start-up cycles
  localparam int OSC_START_CYCLES = 4096;

  // Clock generator modes
  typedef enum logic [3:0] {
    loop_engaged_internal_mode,
    loop_engaged_external_mode,
    loop_bypassed_internal_mode,
    loop_bypassed_external_mode,
    pll_engaged_external_mode,
    pll_bypassed_external_mode,
    low_power_internal_mode,
    low_power_external_mode,
    stop_mode
  } clk_mode_e;

  // Avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } av_req_s;

  // Side-band inputs from the rest of the generator
  typedef struct packed {
    clk_mode_e mode;
    logic osc_request_bit;
    logic ext_reference_enable;
    logic lock_detect_en;
    logic locked;
    logic lock_lost;
    logic ext_clock_lost;
  } gen_state_s;

endpackage : clk_gen_pkg

// ---- osc_ready_tracker.sv ----
// Tracks oscillator start-up and keeps the oscillator-ready flag.
// Assumes mode and enables are synchronous to ref_clk.
`timescale 1ns/1ps
module osc_ready_tracker #(
  parameter int START_CYCLES = clk_gen_pkg::OSC_START_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire clk_gen_pkg::gen_state_s gen,
  output logic ready
);
  import clk_gen_pkg::*;

  localparam int CW = $clog2(START_CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic ready_r;
  logic ready_nxt;
  logic ext_mode;
  logic in_use;
  logic drop;

  // Mode and start-up decode
  always_comb begin
    ext_mode = (gen.mode == loop_engaged_external_mode) ||
               (gen.mode == loop_bypassed_external_mode) ||
               (gen.mode == pll_engaged_external_mode) ||
               (gen.mode == pll_bypassed_external_mode) ||
               (gen.mode == low_power_external_mode);
    in_use = (gen.ext_reference_enable || ext_mode) && gen.osc_request_bit;
    drop = !gen.osc_request_bit ||
           (((gen.mode == loop_engaged_internal_mode) ||
             (gen.mode == loop_bypassed_internal_mode) ||
             (gen.mode == low_power_internal_mode)) && !gen.ext_reference_enable);
    cnt_nxt = cnt_r;
    ready_nxt = ready_r;
    if (drop) begin
      cnt_nxt = '0;
      ready_nxt = 1'b0;
    end else if (in_use) begin
      if (cnt_r != CW'(START_CYCLES)) begin
        cnt_nxt = cnt_r + CW'(1);
      end else begin
        ready_nxt = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ready = ready_r;

endmodule : osc_ready_tracker

// ---- clock_gen_status_pll_control.sv ----
// Contract
// - Ready flag sets after external oscillator start-up
// - Ready clears on request clear or internal mode; the code clears it in internal mode only with ext_reference_enable low
// - Fine trim bit lengthens or shortens period
// - Lock-loss interrupt when enabled and flag set
// - Loop select picks FLL or PLL exclusively
// - Monitor enable requests reset on clock loss
// - Multiplier field gives four times code
// - Reserved codes: high ones act as forty
// - Sticky lock-loss flag, write one clears
//
// Top of the clock generator status and loop control registers.
// Assumes an Avalon-MM master on ref_clk and mode state from the generator core.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module clock_gen_status_pll_control #(
  parameter int START_CYCLES = clk_gen_pkg::OSC_START_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire clk_gen_pkg::av_req_s av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire clk_gen_pkg::gen_state_s gen,
  output logic fine_trim_bit,
  output logic pll_enable,
  output logic fll_enable,
  output logic [5:0] pll_multiplier,
  output logic clock_monitor_reset_req,
  output logic lock_loss_irq,
  output logic irq
);
  import clk_gen_pkg::*;

  // Register state
  logic fine_trim_r;
  logic fine_trim_nxt;
  logic lock_loss_flag_r;
  logic lock_loss_flag_nxt;
  logic [7:0] pll_control_r;
  logic [7:0] pll_control_nxt;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_status_nxt;
  logic [IRQ_W-1:0] irq_enable_r;
  logic [IRQ_W-1:0] irq_enable_nxt;
  logic osc_ready_d_r;
  logic was_locked_r;
  logic was_locked_nxt;

  // Bus state
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Output flops
  logic pll_en_r;
  logic pll_en_nxt;
  logic fll_en_r;
  logic fll_en_nxt;
  logic [5:0] mult_r;
  logic [5:0] mult_nxt;
  logic mon_rst_r;
  logic mon_rst_nxt;
  logic ll_irq_r;
  logic ll_irq_nxt;
  logic irq_r;
  logic irq_nxt;

  logic osc_ready;
  logic lock_exit;
  logic [IRQ_W-1:0] events;
  logic wr_en;
  logic rd_en;

  // Multiplier from the multiplier field
  function automatic logic [5:0] vco_mult(input logic [3:0] code);
    logic [5:0] m;
    m = MULT_MAX;
    if (code == VCO_MULTIPLIER_FIELD_RESERVED) begin
      m = MULT_MAX;
    end else if (code <= VCO_MULTIPLIER_FIELD_LAST) begin
      m = 6'({2'b00, code} * MULT_STEP);
    end
    return m;
  endfunction : vco_mult

  // Status/control read view
  function automatic logic [7:0] status_view(input logic ll, input logic rdy, input logic ft);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_LOCK_LOSS] = ll;
    v[BIT_OSC_READY] = rdy;
    v[BIT_FINE_TRIM] = ft;
    return v;
  endfunction : status_view

  // Oscillator start-up tracking
  osc_ready_tracker #(
    .START_CYCLES(START_CYCLES)
  ) u_osc_ready (
    .ref_clk(ref_clk),
    .rst(rst),
    .gen(gen),
    .ready(osc_ready)
  );

  // Bus strobes: one wait cycle; a write lands on the edge that closes the cycle with waitrequest low
  always_comb begin
    wr_en = av_req.write && ack_r;
    rd_en = av_req.read && !ack_r;
    ack_nxt = (av_req.read || av_req.write) && !ack_r;
  end

  // Event detection for the sticky flags
  always_comb begin
    was_locked_nxt = was_locked_r;
    if (!gen.lock_detect_en) begin
      was_locked_nxt = 1'b0;
    end else if (gen.locked) begin
      was_locked_nxt = 1'b1;
    end
    lock_exit = gen.lock_detect_en && was_locked_r && gen.lock_lost;
    events = '0;
    events[IRQ_LOCK_LOSS] = lock_exit;
    events[IRQ_OSC_READY] = osc_ready && !osc_ready_d_r;
    events[IRQ_CLK_LOSS] = gen.ext_clock_lost && pll_control_r[BIT_CLK_MON_EN];
  end

  // Register writes; hardware set wins over software clear
  always_comb begin
    fine_trim_nxt = fine_trim_r;
    pll_control_nxt = pll_control_r;
    lock_loss_flag_nxt = lock_loss_flag_r;
    irq_enable_nxt = irq_enable_r;
    irq_status_nxt = irq_status_r;
    if (wr_en) begin
      case (av_req.address)
        OFF_STATUS_CONTROL: begin
          fine_trim_nxt = av_req.writedata[BIT_FINE_TRIM];
          if (av_req.writedata[BIT_LOCK_LOSS]) begin
            lock_loss_flag_nxt = 1'b0;
          end
        end
        OFF_PLL_CONTROL: begin
          pll_control_nxt = av_req.writedata[7:0];
          pll_control_nxt[4] = 1'b0;
        end
        OFF_IRQ_STATUS: begin
          irq_status_nxt = irq_status_r & ~av_req.writedata[IRQ_W-1:0];
        end
        OFF_IRQ_ENABLE: begin
          irq_enable_nxt = av_req.writedata[IRQ_W-1:0];
        end
        default: begin
          fine_trim_nxt = fine_trim_r;
        end
      endcase
    end
    if (lock_exit) begin
      lock_loss_flag_nxt = 1'b1;
    end
    irq_status_nxt = irq_status_nxt | events;
  end

  // Read data mux
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      case (av_req.address)
        OFF_STATUS_CONTROL: rdata_nxt = {24'h0000_00, status_view(lock_loss_flag_r,
                                          osc_ready, fine_trim_r)};
        OFF_PLL_CONTROL: rdata_nxt = {24'h0000_00, pll_control_r};
        OFF_IRQ_STATUS: rdata_nxt = {{(32-IRQ_W){1'b0}}, irq_status_r};
        OFF_IRQ_ENABLE: rdata_nxt = 32'h0000_0000;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Control outputs derived from the registers
  always_comb begin
    pll_en_nxt = pll_control_nxt[BIT_LOOP_SELECT];
    fll_en_nxt = !pll_control_nxt[BIT_LOOP_SELECT];
    mult_nxt = vco_mult(pll_control_nxt[VCO_MULTIPLIER_FIELD_MSB:0]);
    mon_rst_nxt = pll_control_r[BIT_CLK_MON_EN] && gen.ext_clock_lost;
    ll_irq_nxt = pll_control_nxt[BIT_LOCK_LOSS_IE] && lock_loss_flag_nxt;
    irq_nxt = |(irq_status_nxt & irq_enable_nxt);
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fine_trim_r <= RST_FINE_TRIM[BIT_FINE_TRIM];
      pll_control_r <= RST_PLL_CONTROL;
      lock_loss_flag_r <= 1'b0;
      irq_status_r <= '0;
      irq_enable_r <= '0;
      osc_ready_d_r <= 1'b0;
      was_locked_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      pll_en_r <= 1'b0;
      fll_en_r <= 1'b1;
      mult_r <= MULT_STEP;
      mon_rst_r <= 1'b0;
      ll_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      fine_trim_r <= fine_trim_nxt;
      pll_control_r <= pll_control_nxt;
      lock_loss_flag_r <= lock_loss_flag_nxt;
      irq_status_r <= irq_status_nxt;
      irq_enable_r <= irq_enable_nxt;
      osc_ready_d_r <= osc_ready;
      was_locked_r <= was_locked_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      pll_en_r <= pll_en_nxt;
      fll_en_r <= fll_en_nxt;
      mult_r <= mult_nxt;
      mon_rst_r <= mon_rst_nxt;
      ll_irq_r <= ll_irq_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Ports straight from flops
  assign av_readdata = rdata_r;
  assign av_waitrequest = !ack_r;
  assign fine_trim_bit = fine_trim_r;
  assign pll_enable = pll_en_r;
  assign fll_enable = fll_en_r;
  assign pll_multiplier = mult_r;
  assign clock_monitor_reset_req = mon_rst_r;
  assign lock_loss_irq = ll_irq_r;
  assign irq = irq_r;

endmodule : clock_gen_status_pll_control

// ---- osc_partner.sv ----
// External oscillator model: reports loss of its clock when told to fail.
// Assumes the bench drives fail in step with ref_clk.
`timescale 1ns/1ps
module osc_partner (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fail,
  output logic clock_lost
);
  logic lost_r;
  logic lost_nxt;
  // Loss shows one cycle after the crystal stops
  always_comb begin
    lost_nxt = rst ? 1'h0 : fail;
  end
  always_ff @(posedge ref_clk) begin
    lost_r <= lost_nxt;
  end
  assign clock_lost = lost_r;
endmodule : osc_partner

// ---- clk_gen_properties.sv ----
// Checker for the status and loop control block.
// Assumes it sees the top module ports only, bound below.
`timescale 1ns/1ps
module clk_gen_properties
  import clk_gen_pkg::*;
#(
  parameter int START_CYCLES = OSC_START_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire clk_gen_pkg::av_req_s av_req,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  input wire clk_gen_pkg::gen_state_s gen,
  input wire logic fine_trim_bit,
  input wire logic pll_enable,
  input wire logic fll_enable,
  input wire logic [5:0] pll_multiplier,
  input wire logic clock_monitor_reset_req,
  input wire logic lock_loss_irq,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic wr0;
  logic wr4;
  // Accepted writes by offset
  assign wr0 = av_req.write && !av_waitrequest && av_req.address == OFF_STATUS_CONTROL;
  assign wr4 = av_req.write && !av_waitrequest && av_req.address == OFF_PLL_CONTROL;
  function automatic logic [5:0] mult_of(input logic [3:0] c);
    return (c == 4'h0 || c > 4'hA) ? 6'h28 : {c, 2'b00};
  endfunction : mult_of
  chk_loop_excl: assert property (pll_enable != fll_enable)
    else $error("loop enables not exclusive");
  chk_mult_legal: assert property (pll_multiplier[1:0] == 2'h0 && pll_multiplier >= 6'h04
    && pll_multiplier <= 6'h28)
    else $error("multiplier out of range");
  chk_trim_write: assert property (wr0 |=> fine_trim_bit == $past(av_req.writedata[0]))
    else $error("fine trim not updated");
  chk_sel_write: assert property (wr4 |=> pll_enable == $past(av_req.writedata[6]))
    else $error("loop select not updated");
  chk_mult_write: assert property (wr4 |=>
    pll_multiplier == mult_of($past(av_req.writedata[3:0])))
    else $error("multiplier mismatch");
  chk_bit4_zero: assert property (av_req.read && !av_waitrequest
    && av_req.address == OFF_PLL_CONTROL |-> av_readdata[4] == 1'h0)
    else $error("bit four not zero");
  chk_mon_cause: assert property (clock_monitor_reset_req |-> $past(gen.ext_clock_lost))
    else $error("reset request without clock loss");
  chk_ll_fall: assert property ($fell(lock_loss_irq) |-> $past(av_req.write))
    else $error("lock loss dropped without write");
  chk_ack_one: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("ack longer than one cycle");
  chk_ack_due: assert property ((av_req.read || av_req.write) && av_waitrequest
    |=> !av_waitrequest)
    else $error("ack late");
  // Main scenarios
  cover property (wr4);
  cover property (lock_loss_irq);
  cover property (clock_monitor_reset_req);
  cover property (irq);
endmodule : clk_gen_properties

bind clock_gen_status_pll_control clk_gen_properties #(.START_CYCLES(START_CYCLES)) props (
  .ref_clk(ref_clk), .rst(rst), .av_req(av_req), .av_readdata(av_readdata),
  .av_waitrequest(av_waitrequest), .gen(gen), .fine_trim_bit(fine_trim_bit),
  .pll_enable(pll_enable), .fll_enable(fll_enable), .pll_multiplier(pll_multiplier),
  .clock_monitor_reset_req(clock_monitor_reset_req), .lock_loss_irq(lock_loss_irq), .irq(irq)
);

// ---- clock_gen_status_pll_control_bench.sv ----
// Self-checking bench for the status and loop control block.
// Assumes the oscillator model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module clock_gen_status_pll_control_bench;
  import clk_gen_pkg::*;
  localparam int START = 8;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  av_req_s req = '0;
  gen_state_s gs = '0;
  gen_state_s gen_w;
  logic fail = 1'h0;
  logic lost, wreq, trim_o, pll_en, fll_en, mon_req, ll_irq, irq;
  logic [5:0] mult;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [7:0] d;
  logic t;
  int err_total = 0;
  int check_count = 0;
  // Clock
  initial forever #25 ref_clk = ~ref_clk;
  // Loss report from the oscillator joins the side-band state
  always_comb begin
    gen_w = gs;
    gen_w.ext_clock_lost = lost;
  end
  clock_gen_status_pll_control #(.START_CYCLES(START)) dut (.ref_clk(ref_clk), .rst(rst),
    .av_req(req), .av_readdata(rdata), .av_waitrequest(wreq), .gen(gen_w),
    .fine_trim_bit(trim_o), .pll_enable(pll_en), .fll_enable(fll_en), .pll_multiplier(mult),
    .clock_monitor_reset_req(mon_req), .lock_loss_irq(ll_irq), .irq(irq));
  osc_partner xtal (.ref_clk(ref_clk), .rst(rst), .fail(fail), .clock_lost(lost));
  function automatic logic [5:0] mult_of(input logic [3:0] c);
    return (c == 4'h0 || c > 4'hA) ? 6'h28 : {c, 2'b00};
  endfunction : mult_of
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    req <= '{read: !wr, write: wr, address: a, writedata: wd};
    do @(posedge ref_clk); while (wreq !== 1'h0);
    q = rdata;
    req <= '0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    d = 8'($urandom(48564));
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    rd(OFF_STATUS_CONTROL, 8'h00);
    rd(OFF_PLL_CONTROL, 8'h01);
    rd(OFF_IRQ_ENABLE, 8'h00);
    chk(fll_en, 1'h1);
    // Software copies its stored trim value itself
    repeat (4) begin
      t = 1'($urandom);
      bus(1'h1, OFF_STATUS_CONTROL, t);
      rd(OFF_STATUS_CONTROL, t);
      chk(trim_o, t);
    end
    // Every multiplier code, bit four set, monitor off
    for (int c = 0; c < 16; c++) begin
      d = 8'(($urandom & 8'hC0) | 8'h10 | c);
      bus(1'h1, OFF_PLL_CONTROL, d);
      rd(OFF_PLL_CONTROL, d & 8'hEF);
      chk(mult, mult_of(4'(c)));
      chk(pll_en, d[6]);
      chk(fll_en, !d[6]);
      chk(ll_irq, 1'h0);
    end
    // Oscillator start-up in an external mode, then drop conditions
    gs.osc_request_bit <= 1'h1;
    gs.mode <= loop_engaged_external_mode;
    rd(OFF_STATUS_CONTROL, t);
    repeat (START + 2) @(posedge ref_clk);
    rd(OFF_STATUS_CONTROL, {1'h1, t});
    rd(OFF_IRQ_STATUS, 8'h02);
    gs.mode <= low_power_internal_mode;
    rd(OFF_STATUS_CONTROL, t);
    gs.mode <= pll_engaged_external_mode;
    repeat (START + 2) @(posedge ref_clk);
    rd(OFF_STATUS_CONTROL, {1'h1, t});
    gs.osc_request_bit <= 1'h0;
    rd(OFF_STATUS_CONTROL, t);
    // Masked, enabled, cleared
    chk(irq, 1'h0);
    bus(1'h1, OFF_IRQ_ENABLE, 8'h02);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'h1);
    bus(1'h1, OFF_IRQ_STATUS, 8'h02);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'h0);
    // Lock lost after locking
    bus(1'h1, OFF_IRQ_ENABLE, 8'h01);
    bus(1'h1, OFF_PLL_CONTROL, 8'hC1);
    gs.lock_detect_en <= 1'h1;
    gs.locked <= 1'h1;
    repeat (2) @(posedge ref_clk);
    gs.lock_lost <= 1'h1;
    gs.locked <= 1'h0;
    @(posedge ref_clk);
    gs.lock_lost <= 1'h0;
    repeat (2) @(negedge ref_clk);
    chk(ll_irq, 1'h1);
    chk(irq, 1'h1);
    bus(1'h1, OFF_STATUS_CONTROL, t);
    rd(OFF_STATUS_CONTROL, 8'h80 | t);
    bus(1'h1, OFF_STATUS_CONTROL, 8'h80 | t);
    rd(OFF_STATUS_CONTROL, t);
    chk(ll_irq, 1'h0);
    bus(1'h1, OFF_IRQ_STATUS, 8'h07);
    rd(OFF_IRQ_STATUS, 8'h00);
    // Monitor on only with the external reference enabled; range never touched
    gs.ext_reference_enable <= 1'h1;
    bus(1'h1, OFF_PLL_CONTROL, 8'h21);
    fail <= 1'h1;
    repeat (4) @(negedge ref_clk);
    chk(mon_req, 1'h1);
    bus(1'h1, OFF_PLL_CONTROL, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk(mon_req, 1'h0);
    rd(OFF_IRQ_STATUS, 8'h04);
    fail <= 1'h0;
    // Unmapped places
    bus(1'h1, 4'h6, 8'hFF);
    rd(OFF_PLL_CONTROL, 8'h01);
    rd(4'h2, 8'h00);
    tally_and_finish();
  end
endmodule : clock_gen_status_pll_control_bench
